// file: src/sfu_fifo_ctrl_port.v
// Operation
// (RULE_01) tx trigger field 00/01/10/11 selects 8/4/2/1 bytes; resets to 00.
// (RULE_02) tx queue low flag high while queued count at or below threshold.
// (RULE_03) modem lines off: clear-to-send seen low, request-to-send driven 0; code sets request_to_send_pin_oe to 0, leaving the rts pin undriven.
// (RULE_04) tx flush bit written 1 discards all queued tx bytes.
// (RULE_05) rx flush bit written 1 discards all stored rx bytes.
// (RULE_06) reset empties both queues regardless of flush bits.
// (RULE_07) queue held empty while its flush bit stays 1.
// (RULE_08) loopback routes serial out to serial in, rts to cts internally.
// (RULE_09) read-only count register: tx count high byte, rx count low byte.
// (RULE_10) tx count in bits 12..8, bits 15..13 zero, 0x10 full.
// (RULE_11) rx count in bits 4..0, bits 7..5 zero, 0x10 full.
// (RULE_12) rts port direction 1 drives rts pin with port data bit.
// (RULE_13) rts port data bit reads live rts pin level.
// (RULE_14) cts port direction 1 drives cts pin with port data bit.
// (RULE_15) cts port data bit reads live cts pin level.
// (RULE_16) break direction 1 drives serial out pin with break data bit.
// (RULE_17) break data bit reads live serial in pin level.
// (RULE_18) software clears modem lines on before using rts/cts as port outputs.
// (RULE_19) software clears tx on before driving break onto serial out.
// (RULE_20) reset clears port register bits; standby does not reinitialise it.
// (RULE_21) port bits 15..8 and 3 read 0; reserved bits written 0.
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`include "sfu_defines.vh"

module sfu_fifo_ctrl_port #(
	parameter DEPTH = 16
) (
	// clock, reset and register bus
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// queue events from the frame logic
	input  wire        tx_push,
	input  wire        tx_pop,
	input  wire        rx_push,
	input  wire        rx_pop,
	// core side of the serial and modem lines
	input  wire        core_txd,
	input  wire        core_rts,
	output reg         core_rxd,
	output reg         core_cts_n,
	// queue status
	output reg  [4:0]  tx_count,
	output reg  [4:0]  rx_count,
	output reg         tx_queue_low_flag,
	output reg         tx_queue_flush,
	output reg         rx_queue_flush,
	// device pins
	output reg         serial_out_pin_o,
	output reg         serial_out_pin_oe,
	input  wire        serial_in_pin,
	input  wire        request_to_send_pin_i,
	output reg         request_to_send_pin_o,
	output reg         request_to_send_pin_oe,
	input  wire        clear_to_send_pin_i,
	output reg         clear_to_send_pin_o,
	output reg         clear_to_send_pin_oe
);

	// ****************************************************************
	// register state
	// ****************************************************************
	reg  [5:0]  fifo_control_r;
	reg         req_send_port_dir_r;
	reg         req_send_port_val_r;
	reg         clr_send_port_dir_r;
	reg         clr_send_port_val_r;
	reg         break_port_dir_r;
	reg         break_port_val_r;
	reg  [4:0]  tx_cnt_r;
	reg  [4:0]  rx_cnt_r;
	reg  [4:0]  tx_cnt_nxt;
	reg  [4:0]  rx_cnt_nxt;
	reg  [4:0]  tx_thr;

	wire        modem_lines_on   = fifo_control_r[`SFU_FC_MODEM_ON];
	wire        tx_queue_flush_b = fifo_control_r[`SFU_FC_TX_FLUSH];
	wire        rx_queue_flush_b = fifo_control_r[`SFU_FC_RX_FLUSH];
	wire        loopback         = fifo_control_r[`SFU_FC_LOOPBACK];
	wire [1:0]  tx_thr_sel       = {fifo_control_r[`SFU_FC_TX_THR_HI],
	                                fifo_control_r[`SFU_FC_TX_THR_LO]};
	wire [4:0]  depth_c          = DEPTH[4:0];

	// ****************************************************************
	// bus slave: write path
	// ****************************************************************
	reg         aw_full_r;
	reg  [3:0]  aw_addr_r;
	reg         w_full_r;
	reg  [15:0] w_data_r;
	reg         w_strb_r;
	wire        do_wr = aw_full_r && w_full_r && !s_axi_bvalid;
	wire        wr_fc = do_wr && (aw_addr_r == `SFU_ADDR_FIFO_CONTROL);
	wire        wr_sp = do_wr && (aw_addr_r == `SFU_ADDR_SERIAL_PIN_PORT);
	wire        wr_ok = (aw_addr_r == `SFU_ADDR_FIFO_CONTROL) ||
	                    (aw_addr_r == `SFU_ADDR_FIFO_FILL_COUNT) ||
	                    (aw_addr_r == `SFU_ADDR_SERIAL_PIN_PORT);
	wire [1:0]  wr_resp = wr_ok ? `SFU_RESP_OKAY : `SFU_RESP_SLVERR;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SFU_RESP_OKAY;
			aw_full_r     <= 1'b0;
			aw_addr_r     <= 4'h0;
			w_full_r      <= 1'b0;
			w_data_r      <= 16'h0000;
			w_strb_r      <= 1'b0;
		end else begin
			// ready is a one-cycle pulse; the master holds valid, so it always meets it
			if (s_axi_awready)
				s_axi_awready <= 1'b0;
			else if (s_axi_awvalid && !aw_full_r && !s_axi_bvalid)
				s_axi_awready <= 1'b1;
			if (s_axi_wready)
				s_axi_wready <= 1'b0;
			else if (s_axi_wvalid && !w_full_r && !s_axi_bvalid)
				s_axi_wready <= 1'b1;
			if (s_axi_awready && s_axi_awvalid) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr[`SFU_ADDR_W-1:0];
			end
			if (s_axi_wready && s_axi_wvalid) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata[15:0];
				w_strb_r <= s_axi_wstrb[0];
			end
			if (do_wr) begin
				aw_full_r    <= 1'b0;
				w_full_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_resp;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// control and port registers
	// ****************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			fifo_control_r      <= `SFU_FC_RESET;               // [RULE_01]
			req_send_port_dir_r <= `SFU_SP_RESET;               // [RULE_20]
			req_send_port_val_r <= `SFU_SP_RESET;
			clr_send_port_dir_r <= `SFU_SP_RESET;
			clr_send_port_val_r <= `SFU_SP_RESET;
			break_port_dir_r    <= `SFU_SP_RESET;
			break_port_val_r    <= `SFU_SP_RESET;
		end else begin
			if (wr_fc && w_strb_r)
				fifo_control_r <= w_data_r[5:0];
			// only writable bits are stored; reserved bits have no flops [RULE_21]
			if (wr_sp && w_strb_r) begin
				req_send_port_dir_r <= w_data_r[`SFU_SP_RTS_DIR];
				req_send_port_val_r <= w_data_r[`SFU_SP_RTS_VAL];
				clr_send_port_dir_r <= w_data_r[`SFU_SP_CTS_DIR];
				clr_send_port_val_r <= w_data_r[`SFU_SP_CTS_VAL];
				break_port_dir_r    <= w_data_r[`SFU_SP_BRK_DIR];
				break_port_val_r    <= w_data_r[`SFU_SP_BRK_VAL];
			end
		end
	end

	// ****************************************************************
	// queue fill counters
	// ****************************************************************
	always @* begin
		tx_cnt_nxt = tx_cnt_r;
		if (tx_push && !tx_pop && tx_cnt_r != depth_c)
			tx_cnt_nxt = tx_cnt_r + 5'd1;
		else if (tx_pop && !tx_push && tx_cnt_r != 5'd0)
			tx_cnt_nxt = tx_cnt_r - 5'd1;
		// flush outranks push and pop in the same cycle
		if (tx_queue_flush_b)
			tx_cnt_nxt = 5'd0;                                  // [RULE_04] [RULE_07]
		rx_cnt_nxt = rx_cnt_r;
		if (rx_push && !rx_pop && rx_cnt_r != depth_c)
			rx_cnt_nxt = rx_cnt_r + 5'd1;
		else if (rx_pop && !rx_push && rx_cnt_r != 5'd0)
			rx_cnt_nxt = rx_cnt_r - 5'd1;
		if (rx_queue_flush_b)
			rx_cnt_nxt = 5'd0;                                  // [RULE_05] [RULE_07]
	end

	// ****************************************************************
	// transmit trigger decode
	// ****************************************************************
	always @* begin
		case (tx_thr_sel)                                       // [RULE_01]
			`SFU_THR_SEL_8: tx_thr = `SFU_THR_8;
			`SFU_THR_SEL_4: tx_thr = `SFU_THR_4;
			`SFU_THR_SEL_2: tx_thr = `SFU_THR_2;
			default:        tx_thr = `SFU_THR_1;
		endcase
	end

	// ****************************************************************
	// queue counters and status
	// ****************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_cnt_r          <= 5'd0;                          // [RULE_06]
			rx_cnt_r          <= 5'd0;                          // [RULE_06]
			tx_count          <= 5'd0;
			rx_count          <= 5'd0;
			tx_queue_low_flag <= 1'b1;
			tx_queue_flush    <= 1'b0;
			rx_queue_flush    <= 1'b0;
		end else begin
			tx_cnt_r          <= tx_cnt_nxt;
			rx_cnt_r          <= rx_cnt_nxt;
			tx_count          <= tx_cnt_nxt;
			rx_count          <= rx_cnt_nxt;
			tx_queue_low_flag <= (tx_cnt_nxt <= tx_thr);      // [RULE_02]
			tx_queue_flush    <= tx_queue_flush_b;
			rx_queue_flush    <= rx_queue_flush_b;
		end
	end

	// ****************************************************************
	// pin steering and loopback
	// ****************************************************************
	// modem rts as the core would drive it, before any port override
	wire rts_core_lvl = modem_lines_on ? core_rts : 1'b0;      // [RULE_03]

	always @(posedge aclk) begin
		if (!aresetn) begin
			serial_out_pin_o       <= 1'b1;
			serial_out_pin_oe      <= 1'b1;
			request_to_send_pin_o  <= 1'b0;
			request_to_send_pin_oe <= 1'b0;
			clear_to_send_pin_o    <= 1'b0;
			clear_to_send_pin_oe   <= 1'b0;
		end else begin
			// in loopback the pin idles at mark unless break direction drives it, so the far end sees no traffic
			if (break_port_dir_r)
				serial_out_pin_o <= break_port_val_r;          // [RULE_16]
			else
				serial_out_pin_o <= loopback ? 1'b1 : core_txd;
			serial_out_pin_oe <= 1'b1;
			if (req_send_port_dir_r) begin
				request_to_send_pin_o  <= req_send_port_val_r; // [RULE_12]
				request_to_send_pin_oe <= 1'b1;
			end else begin
				request_to_send_pin_o  <= rts_core_lvl;        // [RULE_03]
				request_to_send_pin_oe <= modem_lines_on && !loopback;
			end
			clear_to_send_pin_o  <= clr_send_port_val_r;      // [RULE_14]
			clear_to_send_pin_oe <= clr_send_port_dir_r;      // [RULE_14]
		end
	end

	// ****************************************************************
	// core inputs and loopback
	// ****************************************************************
	// in loopback the pins stay visible only through the port register
	always @(posedge aclk) begin
		if (!aresetn) begin
			core_rxd   <= 1'b1;
			core_cts_n <= 1'b0;
		end else begin
			core_rxd <= loopback ? core_txd : serial_in_pin;   // [RULE_08]
			if (!modem_lines_on)
				core_cts_n <= 1'b0;                            // [RULE_03]
			else
				core_cts_n <= loopback ? core_rts : clear_to_send_pin_i; // [RULE_08]
		end
	end

	// ****************************************************************
	// bus slave: read path
	// ****************************************************************
	reg  [31:0] rd_mux;
	reg         rd_ok;

	always @* begin
		rd_mux = 32'h0000_0000;
		rd_ok  = 1'b1;
		// upper address bits are not decoded, so the map repeats
		case (s_axi_araddr[`SFU_ADDR_W-1:0])
			`SFU_ADDR_FIFO_CONTROL:
				rd_mux[5:0] = fifo_control_r;
			`SFU_ADDR_FIFO_FILL_COUNT: begin
				rd_mux[`SFU_CNT_TX_LSB +: `SFU_CNT_W] = tx_cnt_r; // [RULE_09] [RULE_10]
				rd_mux[`SFU_CNT_RX_LSB +: `SFU_CNT_W] = rx_cnt_r; // [RULE_11]
			end
			`SFU_ADDR_SERIAL_PIN_PORT: begin
				rd_mux[`SFU_SP_RTS_DIR] = req_send_port_dir_r;
				rd_mux[`SFU_SP_RTS_VAL] = request_to_send_pin_i;  // [RULE_13]
				rd_mux[`SFU_SP_CTS_DIR] = clr_send_port_dir_r;
				rd_mux[`SFU_SP_CTS_VAL] = clear_to_send_pin_i;    // [RULE_15]
				rd_mux[`SFU_SP_BRK_DIR] = break_port_dir_r;
				rd_mux[`SFU_SP_BRK_VAL] = serial_in_pin;          // [RULE_17]
				// bits 3 and 2 stay 0
			end
			default:
				rd_ok = 1'b0;
		endcase
	end

	// ****************************************************************
	// read handshake
	// ****************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `SFU_RESP_OKAY;
		end else begin
			if (s_axi_arready)
				s_axi_arready <= 1'b0;
			else if (s_axi_arvalid && !s_axi_rvalid)
				s_axi_arready <= 1'b1;
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_ok ? `SFU_RESP_OKAY : `SFU_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // sfu_fifo_ctrl_port

// file: inc/sfu_defines.vh
`ifndef SFU_DEFINES_VH
`define SFU_DEFINES_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define SFU_ADDR_FIFO_CONTROL    4'h0
`define SFU_ADDR_FIFO_FILL_COUNT 4'h4
`define SFU_ADDR_SERIAL_PIN_PORT 4'h8
`define SFU_ADDR_W               4

// ****************************************************************
// fifo_control fields
// ****************************************************************
`define SFU_FC_TX_THR_HI   5
`define SFU_FC_TX_THR_LO   4
`define SFU_FC_MODEM_ON    3
`define SFU_FC_TX_FLUSH    2
`define SFU_FC_RX_FLUSH    1
`define SFU_FC_LOOPBACK    0
`define SFU_FC_RESET       6'h00
`define SFU_FC_RW_MASK     16'h003F

// ****************************************************************
// fifo_fill_count fields
// ****************************************************************
`define SFU_CNT_TX_LSB     8
`define SFU_CNT_RX_LSB     0
`define SFU_CNT_W          5

// ****************************************************************
// serial_pin_port fields
// ****************************************************************
`define SFU_SP_RTS_DIR     7
`define SFU_SP_RTS_VAL     6
`define SFU_SP_CTS_DIR     5
`define SFU_SP_CTS_VAL     4
`define SFU_SP_BRK_DIR     1
`define SFU_SP_BRK_VAL     0
`define SFU_SP_RESET       1'b0

// ****************************************************************
// transmit trigger thresholds
// ****************************************************************
`define SFU_THR_SEL_8      2'b00
`define SFU_THR_SEL_4      2'b01
`define SFU_THR_SEL_2      2'b10
`define SFU_THR_8          5'h08
`define SFU_THR_4          5'h04
`define SFU_THR_2          5'h02
`define SFU_THR_1          5'h01

// ****************************************************************
// bus answers
// ****************************************************************
`define SFU_RESP_OKAY      2'b00
`define SFU_RESP_SLVERR    2'b10

`endif

// file: testbench/sfu_fifo_ctrl_port_chk.sv
// ****************************************************************
// port-level checks
// ****************************************************************
module sfu_fifo_ctrl_port_chk #(
	parameter int DEPTH = 16
) (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       tx_push,
	input wire logic       tx_pop,
	input wire logic [4:0] tx_count,
	input wire logic [4:0] rx_count,
	input wire logic       tx_queue_low_flag,
	input wire logic       tx_queue_flush,
	input wire logic       rx_queue_flush,
	input wire logic       core_txd,
	input wire logic       core_rts,
	input wire logic       core_rxd,
	input wire logic       core_cts_n,
	input wire logic       serial_in_pin,
	input wire logic       clear_to_send_pin_i,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_flag_empty: assert property (tx_count == 5'h00 |-> tx_queue_low_flag)
		else $error("low flag clear on empty queue");
	a_flag_above: assert property (tx_count > 5'h08 |-> !tx_queue_low_flag)
		else $error("low flag set above every threshold");
	a_tx_flush_hold: assert property (tx_queue_flush [*2] |-> tx_count == 5'h00)
		else $error("tx queue not held empty");
	a_rx_flush_hold: assert property (rx_queue_flush [*2] |-> rx_count == 5'h00)
		else $error("rx queue not held empty");
	a_reset_empty: assert property (disable iff (1'b0) !aresetn |=>
		tx_count == 5'h00 && rx_count == 5'h00) else $error("queue kept across reset");
	a_tx_step: assert property (tx_push && !tx_pop && !tx_queue_flush && tx_count < 5'h10
		|=> tx_count == $past(tx_count) + 5'h01) else $error("tx count missed a push");
	a_count_limit: assert property (tx_count <= DEPTH && rx_count <= DEPTH)
		else $error("count beyond queue depth");
	// modem off forces 0, else pin or looped request, one clock late
	a_cts_source: assert property (core_cts_n == 1'b0 ||
		core_cts_n == $past(clear_to_send_pin_i) || core_cts_n == $past(core_rts))
		else $error("clear-to-send from no legal source");
	a_rxd_source: assert property (core_rxd == $past(serial_in_pin) ||
		core_rxd == $past(core_txd)) else $error("receive data from no legal source");
	a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
endmodule // sfu_fifo_ctrl_port_chk

// file: testbench/sfu_remote_model.sv
// ****************************************************************
// far end: echoes our line and grants clear-to-send, LAT clocks late
// ****************************************************************
module sfu_remote_model #(
	parameter int LAT = 2
) (
	input  wire logic aclk,
	input  wire logic line_in,
	input  wire logic rts_seen,
	output wire logic line_out,
	output wire logic cts_drive
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] line_r;
	logic [7:0] rts_r;
	always @(posedge aclk) begin
		line_r <= {line_r[6:0], line_in};
		rts_r  <= {rts_r[6:0], rts_seen};
	end
	assign line_out  = line_r[LAT-1];
	assign cts_drive = rts_r[LAT-1];
endmodule // sfu_remote_model

// file: testbench/tb_sfu_fifo_ctrl_port.sv
// ****************************************************************
// register, queue and pin scenarios
// ****************************************************************
module tb_sfu_fifo_ctrl_port;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] FC = 32'h0000_0000;
	localparam logic [31:0] CN = 32'h0000_0004;
	localparam logic [31:0] SP = 32'h0000_0008;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, core_txd, core_rts;
	logic [31:0] awaddr, wdata, araddr, rd;
	logic [3:0]  qp, wstrb;
	logic [1:0]  rs;
	logic [7:0]  thr [4] = '{8'h08, 8'h04, 8'h02, 8'h01};
	wire         awready, wready, bvalid, arready, rvalid, flag, txo, sin, far_cts;
	wire         rts_o, rts_oe, cts_o, cts_oe, core_rxd, core_cts_n, txo_oe;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	wire         rts_w = rts_oe ? rts_o : 1'b1;  // pulled up when undriven
	wire         cts_w = cts_oe ? cts_o : far_cts;
	int          mismatches, checks;

	sfu_fifo_ctrl_port sfu_fifo_ctrl_port_inst (.aclk, .aresetn, .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.tx_push(qp[3]), .tx_pop(qp[2]), .rx_push(qp[1]), .rx_pop(qp[0]), .core_txd,
		.core_rts, .core_rxd, .core_cts_n, .tx_count(), .rx_count(), .tx_queue_low_flag(flag),
		.tx_queue_flush(), .rx_queue_flush(), .serial_out_pin_o(txo), .serial_out_pin_oe(txo_oe),
		.serial_in_pin(sin), .request_to_send_pin_i(rts_w), .request_to_send_pin_o(rts_o),
		.request_to_send_pin_oe(rts_oe), .clear_to_send_pin_i(cts_w),
		.clear_to_send_pin_o(cts_o), .clear_to_send_pin_oe(cts_oe));
	sfu_remote_model sfu_remote_model_inst (.aclk, .line_in(txo), .rts_seen(rts_w),
		.line_out(sin), .cts_drive(far_cts));

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		chk_w({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rdx(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rck(input logic [31:0] a, input logic [31:0] e);
		rdx(a, rd, rs);
		chk_w(rd, e);
	endtask
	// pulses stay high n clocks back to back; n must be at least 1
	task automatic pulse(input logic [3:0] m, input int n);
		@(posedge aclk);
		qp <= m;
		repeat (n) @(posedge aclk);
		qp <= 4'h0;
		@(posedge aclk);
	endtask
	task automatic finish_test();
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		finish_test();
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, qp} = 10'h000;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb = 4'hF;
		core_txd = 1'b1;
		core_rts = 1'b1;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rck(FC, 32'h0000_0000);
		rck(CN, 32'h0000_0000);
		rck(SP, 32'h0000_0051);
		for (int i = 0; i < 4; i++) begin
			wr(FC, 32'h0000_0004 | 32'(i << 4), rs);
			wr(FC, 32'(i << 4), rs);
			pulse(4'h8, thr[i]);
			chk_b(flag, 1'b1);
			pulse(4'h8, 1);
			chk_b(flag, 1'b0);
			rck(CN, {16'h0000, thr[i] + 8'h01, 8'h00});
		end
		wr(FC, 32'h0000_0006, rs);
		wr(FC, 32'h0000_0000, rs);
		pulse(4'hA, 18);
		rck(CN, 32'h0000_1010);
		wr(CN, 32'h0000_0000, rs);
		chk_w(32'(rs), 32'h0000_0000);
		pulse(4'h5, 1);
		rck(CN, 32'h0000_0F0F);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rck(CN, 32'h0000_0000);
		pulse(4'hA, 3);
		wr(FC, 32'h0000_0006, rs);
		pulse(4'hA, 3);
		rck(CN, 32'h0000_0000);
		wr(FC, 32'h0000_0000, rs);
		pulse(4'hA, 1);
		rck(CN, 32'h0000_0101);
		repeat (6) @(posedge aclk);
		chk_b(core_cts_n, 1'b0);
		chk_b(rts_o, 1'b0);
		wr(FC, 32'h0000_0008, rs);
		repeat (6) @(posedge aclk);
		chk_b(core_cts_n, 1'b1);
		core_rts <= 1'b0;
		repeat (6) @(posedge aclk);
		chk_b(core_cts_n, 1'b0);
		wr(FC, 32'h0000_0009, rs);
		core_txd <= 1'b0;
		repeat (6) @(posedge aclk);
		chk_b(core_rxd, 1'b0);
		chk_b(core_cts_n, 1'b0);
		core_txd <= 1'b1;
		// modem lines off and transmitter idle before port use
		wr(FC, 32'h0000_0000, rs);
		for (int v = 0; v < 2; v++) begin
			wr(SP, 32'h0000_00A2 | (v * 32'h0000_0051), rs);
			repeat (6) @(posedge aclk);
			chk_b(rts_o, v[0]);
			chk_b(cts_o, v[0]);
			chk_b(txo, v[0]);
			chk_b(txo_oe, 1'b1);
			rdx(SP, rd, rs);
			chk_w(rd & 32'hFFFF_FFFB, 32'h0000_00A2 | (v * 32'h0000_0051));
		end
		wr(SP, 32'h0000_0051, rs);
		core_txd <= 1'b0;
		repeat (4) @(posedge aclk);
		chk_b(rts_oe, 1'b0);
		chk_b(cts_oe, 1'b0);
		chk_b(txo, 1'b0);
		core_txd <= 1'b1;
		wr(FC, 32'h0000_FFFF, rs);
		rck(FC, 32'h0000_003F);
		// low byte lane off: the write must leave the register alone
		wstrb <= 4'hE;
		wr(FC, 32'h0000_0000, rs);
		rck(FC, 32'h0000_003F);
		wr(32'h0000_000C, 32'h0000_FFFF, rs);
		chk_w(32'(rs), 32'h0000_0002);
		rdx(32'h0000_000C, rd, rs);
		chk_w(32'(rs), 32'h0000_0002);
		finish_test();
	end
endmodule // tb_sfu_fifo_ctrl_port

bind sfu_fifo_ctrl_port sfu_fifo_ctrl_port_chk #(.DEPTH(DEPTH)) sfu_fifo_ctrl_port_chk_inst (
	.aclk, .aresetn, .tx_push, .tx_pop, .tx_count, .rx_count, .tx_queue_low_flag,
	.tx_queue_flush, .rx_queue_flush, .core_txd, .core_rts, .core_rxd, .core_cts_n,
	.serial_in_pin, .clear_to_send_pin_i, .s_axi_rvalid, .s_axi_rready);
